// >>> hw/cpmsr_core_regs.sv
// Function
// - only privileged handler, privileged thread, user thread
// - user-level restricted access blocked and faults
// - privileged level accesses everything, faulting only on narrow r8-r12 writes and instruction-set bit clears
// - handler mode while servicing exception, else thread
// - all sixteen core registers 32 bits
// - 16-bit instruction writes to r8-r12 fault and are dropped
// - process stack in thread mode when control bit zero or one is set
// - stack pointer low two bits forced zero
// - subroutine call writes return address to link
// - program counter bit zero forced zero
// - status word accessed whole or per part
// - application part holds flags in top bits
// - interrupt part holds current exception number
// - execution part holds continuable and conditional fields
// - instruction-set bit reads one, clearing faults
// - general mask passes only nmi and hard fault
// - fault mask passes only nmi
// - threshold blocks priorities equal or above it
// - zero threshold disables priority masking
// - control bit zero selects thread privilege
// - control bit one selects alternate stack
// - stack-select bit stays zero in handler mode
`timescale 1ns/1ps
`include "cpmsr_defines.svh"
module cpmsr_core_regs import cpmsr_pkg::*; #(
   parameter int BPRI_W = 9
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [3:0] GPR_RD_IDX,
   output logic [31:0] GPR_RD_DATA,
   input wire logic GPR_WE,
   input wire logic [3:0] GPR_WR_IDX,
   input wire logic [31:0] GPR_WR_DATA,
   input wire logic GPR_NARROW,
   input wire logic SPR_WE,
   input wire logic SPR_RE,
   input wire logic [3:0] SPR_SEL,
   input wire logic [31:0] SPR_WR_DATA,
   output logic [31:0] SPR_RD_DATA,
   input wire logic RESTRICTED_OP,
   input wire logic CALL_EN,
   input wire logic [31:0] CALL_RET_ADDR,
   input wire logic EXC_ENTER,
   input wire logic [8:0] EXC_NUM,
   input wire logic EXC_RETURN,
   input wire logic [1:0] IRQ_KIND,
   input wire logic [8:0] IRQ_PRIO,
   output logic IRQ_ACCEPT,
   output logic FAULT,
   output logic [1:0] MODE,
   output logic PSP_ACTIVE
);
   // state
   cpmsr_word_t gpr_r [0:12];
   cpmsr_word_t msp_r, psp_r, lr_r, pc_r;
   logic [4:0] app_status_part_r;
   logic [8:0] irq_status_part_r;
   logic [5:0] ici_r;
   logic [1:0] it_r;
   logic pri_r, flt_r, spsel_save_r, fault_r, fault_seen_r;
   logic [BPRI_W-1:0] bpri_r;
   logic [1:0] ctrl_r, ctrl_nxt;
   cpmsr_mode_e mode_r, mode_nxt;
   logic handler, user, psp_act;
   cpmsr_word_t psw_word;
   // axi holding state
   logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
   cpmsr_idx_t aw_idx_r;
   logic aw_hi_r;
   cpmsr_word_t wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   // unified write port
   logic w_en, w_axi, w_go, axi_go;
   cpmsr_idx_t w_idx;
   cpmsr_word_t w_data;
   logic f_tbit, f_narrow, f_spr, f_op, f_blk, f_any;

   assign handler = (mode_r == CPMSR_PRIV_HANDLER);
   assign user = (mode_r == CPMSR_USER_THREAD);
   assign psp_act = !handler && (ctrl_r[1] || ctrl_r[0]);
   assign psw_word = {app_status_part_r, it_r, 1'b1, 8'h00, ici_r, 1'b0, irq_status_part_r};

   function automatic logic mapped(input cpmsr_idx_t i);
      mapped = (i <= `CPMSR_IDX_CTRL) || (i == `CPMSR_IDX_STAT);
   endfunction

   function automatic cpmsr_word_t rd_word(input cpmsr_idx_t i);
      case (i)
         `CPMSR_IDX_SP: rd_word = psp_act ? psp_r : msp_r;
         `CPMSR_IDX_LR: rd_word = lr_r;
         `CPMSR_IDX_PC: rd_word = pc_r;
         `CPMSR_IDX_PSW: rd_word = psw_word;
         `CPMSR_IDX_APP_STATUS_PART: rd_word = {app_status_part_r, 27'h0000000};
         `CPMSR_IDX_IRQ_STATUS_PART: rd_word = {23'h000000, irq_status_part_r};
         `CPMSR_IDX_EXEC_STATUS_PART: rd_word = {5'h00, it_r, 1'b1, 8'h00, ici_r, 10'h000};
         `CPMSR_IDX_MSP: rd_word = msp_r;
         `CPMSR_IDX_PSP: rd_word = psp_r;
         `CPMSR_IDX_PRI: rd_word = {31'h00000000, pri_r};
         `CPMSR_IDX_FLT: rd_word = {31'h00000000, flt_r};
         `CPMSR_IDX_BPRI: rd_word = {{(32-BPRI_W){1'b0}}, bpri_r};
         `CPMSR_IDX_CTRL: rd_word = {30'h00000000, ctrl_r};
         `CPMSR_IDX_STAT: rd_word = {28'h0000000, psp_act, mode_r, fault_seen_r};
         default: rd_word = (i < `CPMSR_IDX_SP) ? gpr_r[i[3:0]] : `CPMSR_RST_WORD;
      endcase
   endfunction

   function automatic cpmsr_word_t merge(input cpmsr_word_t old, input cpmsr_word_t nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // one write per cycle: gpr, then special, then bus
   assign axi_go = aw_hold_r && w_hold_r && !bvalid_r && !GPR_WE && !SPR_WE;
   always_comb begin
      w_en = 1'b0;
      w_axi = 1'b0;
      w_idx = 5'h00;
      w_data = `CPMSR_RST_WORD;
      if (GPR_WE) begin
         w_en = 1'b1;
         w_idx = {1'b0, GPR_WR_IDX};
         w_data = GPR_WR_DATA;
      end else if (SPR_WE) begin
         w_en = 1'b1;
         w_idx = `CPMSR_SPR_BASE + {1'b0, SPR_SEL};
         w_data = SPR_WR_DATA;
      end else if (axi_go && !aw_hi_r && mapped(aw_idx_r)) begin
         w_en = 1'b1;
         w_axi = 1'b1;
         w_idx = aw_idx_r;
         w_data = merge(rd_word(aw_idx_r), wdata_r, wstrb_r);
      end
   end

   assign f_tbit = w_en && (w_idx == `CPMSR_IDX_PSW || w_idx == `CPMSR_IDX_EXEC_STATUS_PART)
                   && !w_data[`CPMSR_TBIT];
   assign f_narrow = GPR_WE && GPR_NARROW && ({1'b0, GPR_WR_IDX} >= `CPMSR_HIGH_LO)
                     && ({1'b0, GPR_WR_IDX} <= `CPMSR_HIGH_HI);
   assign f_spr = (SPR_WE || SPR_RE) && user && (SPR_SEL != `CPMSR_SEL_APP_STATUS_PART);
   assign f_op = RESTRICTED_OP && user;
   assign f_blk = f_tbit || f_narrow || f_spr;
   assign f_any = f_blk || f_op;
   assign w_go = w_en && !f_blk;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 0; i < 13; i++) begin
            gpr_r[i] <= `CPMSR_RST_WORD;
         end
      end else if (w_go && w_idx < `CPMSR_IDX_SP) begin
         gpr_r[w_idx[3:0]] <= w_data;
      end
   end

   // banked stack pointers
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         msp_r <= `CPMSR_RST_WORD;
         psp_r <= `CPMSR_RST_WORD;
      end else if (w_go) begin
         if (w_idx == `CPMSR_IDX_MSP || (w_idx == `CPMSR_IDX_SP && !psp_act)) begin
            msp_r <= w_data & `CPMSR_SP_MASK;
         end
         if (w_idx == `CPMSR_IDX_PSP || (w_idx == `CPMSR_IDX_SP && psp_act)) begin
            psp_r <= w_data & `CPMSR_SP_MASK;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         lr_r <= `CPMSR_RST_WORD;
      end else if (CALL_EN) begin
         lr_r <= CALL_RET_ADDR;
      end else if (w_go && w_idx == `CPMSR_IDX_LR) begin
         lr_r <= w_data;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pc_r <= `CPMSR_RST_WORD;
      end else if (w_go && w_idx == `CPMSR_IDX_PC) begin
         pc_r <= w_data & `CPMSR_PC_MASK;
      end
   end

   // status word parts; exception number is hardware owned
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         app_status_part_r <= 5'h00;
         ici_r <= 6'h00;
         it_r <= 2'h0;
      end else if (w_go) begin
         if (w_idx == `CPMSR_IDX_PSW || w_idx == `CPMSR_IDX_APP_STATUS_PART) begin
            app_status_part_r <= w_data[31:27];
         end
         if (w_idx == `CPMSR_IDX_PSW || w_idx == `CPMSR_IDX_EXEC_STATUS_PART) begin
            ici_r <= w_data[15:10];
            it_r <= w_data[26:25];
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         irq_status_part_r <= 9'h000;
      end else if (EXC_ENTER) begin
         irq_status_part_r <= EXC_NUM;
      end else if (EXC_RETURN) begin
         irq_status_part_r <= 9'h000;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pri_r <= 1'b0;
         flt_r <= 1'b0;
         bpri_r <= '0;
      end else if (w_go) begin
         if (w_idx == `CPMSR_IDX_PRI) begin
            pri_r <= w_data[0];
         end
         if (w_idx == `CPMSR_IDX_FLT) begin
            flt_r <= w_data[0];
         end
         if (w_idx == `CPMSR_IDX_BPRI) begin
            bpri_r <= w_data[BPRI_W-1:0];
         end
      end
   end

   // interrupt acceptance against the three masks
   always_comb begin
      if (IRQ_KIND == `CPMSR_KIND_NMI) begin
         IRQ_ACCEPT = 1'b1;
      end else if (IRQ_KIND == `CPMSR_KIND_HARD) begin
         IRQ_ACCEPT = !flt_r;
      end else begin
         IRQ_ACCEPT = !flt_r && !pri_r
                      && (bpri_r == '0 || IRQ_PRIO < bpri_r);
      end
   end

   // control register and operating mode
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (EXC_ENTER) begin
         ctrl_nxt[1] = 1'b0;
      end else if (EXC_RETURN) begin
         ctrl_nxt[1] = spsel_save_r;
      end
      if (w_go && w_idx == `CPMSR_IDX_CTRL) begin
         ctrl_nxt[0] = w_data[0];
         if (!handler && !EXC_ENTER) begin
            ctrl_nxt[1] = w_data[1];
         end
      end
   end

   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         CPMSR_PRIV_HANDLER: begin
            if (EXC_RETURN && !EXC_ENTER) begin
               mode_nxt = ctrl_nxt[0] ? CPMSR_USER_THREAD : CPMSR_PRIV_THREAD;
            end
         end
         CPMSR_PRIV_THREAD, CPMSR_USER_THREAD: begin
            if (EXC_ENTER) begin
               mode_nxt = CPMSR_PRIV_HANDLER;
            end else begin
               mode_nxt = ctrl_nxt[0] ? CPMSR_USER_THREAD : CPMSR_PRIV_THREAD;
            end
         end
         default: mode_nxt = CPMSR_PRIV_THREAD;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_r <= 2'h0;
         mode_r <= CPMSR_PRIV_THREAD;
         spsel_save_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         mode_r <= mode_nxt;
         if (EXC_ENTER && !handler) begin
            spsel_save_r <= ctrl_r[1];
         end
      end
   end

   // fault pulse and sticky record; set beats clear
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         fault_r <= 1'b0;
         fault_seen_r <= 1'b0;
      end else begin
         fault_r <= f_any;
         if (f_any) begin
            fault_seen_r <= 1'b1;
         end else if (w_go && w_idx == `CPMSR_IDX_STAT && w_data[0]) begin
            fault_seen_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         GPR_RD_DATA <= `CPMSR_RST_WORD;
         SPR_RD_DATA <= `CPMSR_RST_WORD;
      end else begin
         GPR_RD_DATA <= rd_word({1'b0, GPR_RD_IDX});
         if (SPR_RE) begin
            SPR_RD_DATA <= f_spr ? `CPMSR_RST_WORD : rd_word(`CPMSR_SPR_BASE + {1'b0, SPR_SEL});
         end
      end
   end

   // axi write channels
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         bvalid_r <= 1'b0;
         aw_idx_r <= 5'h00;
         aw_hi_r <= 1'b0;
         wdata_r <= `CPMSR_RST_WORD;
         wstrb_r <= 4'h0;
         bresp_r <= `CPMSR_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && !aw_hold_r) begin
            aw_hold_r <= 1'b1;
            aw_idx_r <= S_AXI_AWADDR[6:2];
            aw_hi_r <= S_AXI_AWADDR[7];
         end
         if (S_AXI_WVALID && !w_hold_r) begin
            w_hold_r <= 1'b1;
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end
         if (axi_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (w_axi && !f_tbit) ? `CPMSR_RESP_OKAY : `CPMSR_RESP_SLVERR;
         end else if (bvalid_r && S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // axi read channel
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rvalid_r <= 1'b0;
         rdata_r <= `CPMSR_RST_WORD;
         rresp_r <= `CPMSR_RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_r) begin
         rvalid_r <= 1'b1;
         if (!S_AXI_ARADDR[7] && mapped(S_AXI_ARADDR[6:2])) begin
            rdata_r <= rd_word(S_AXI_ARADDR[6:2]);
            rresp_r <= `CPMSR_RESP_OKAY;
         end else begin
            rdata_r <= `CPMSR_RST_WORD;
            rresp_r <= `CPMSR_RESP_SLVERR;
         end
      end else if (rvalid_r && S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   assign S_AXI_AWREADY = !aw_hold_r;
   assign S_AXI_WREADY = !w_hold_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign FAULT = fault_r;
   assign MODE = mode_r;
   assign PSP_ACTIVE = psp_act;

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   property p_user_thread_only;
      user |-> ctrl_r[0] && !handler;
   endproperty
   a_user_thread_only: assert property (p_user_thread_only) else $error("user outside thread");

   property p_user_spr_fault;
      (SPR_WE && user && SPR_SEL != `CPMSR_SEL_APP_STATUS_PART) |=> FAULT && $stable(ctrl_r);
   endproperty
   a_user_spr_fault: assert property (p_user_spr_fault) else $error("user access not faulted");

   property p_priv_no_fault;
      (!user && !f_narrow && !f_tbit) |=> !FAULT;
   endproperty
   a_priv_no_fault: assert property (p_priv_no_fault) else $error("privileged access faulted");

   property p_enter_handler;
      EXC_ENTER |=> handler ##1 (handler || $past(EXC_RETURN));
   endproperty
   a_enter_handler: assert property (p_enter_handler) else $error("handler not entered");

   property p_narrow_fault;
      f_narrow |=> FAULT;
   endproperty
   a_narrow_fault: assert property (p_narrow_fault) else $error("high register not faulted");

   property p_psp_sel;
      (user |-> PSP_ACTIVE) and (handler |-> !PSP_ACTIVE);
   endproperty
   a_psp_sel: assert property (p_psp_sel) else $error("wrong stack bank");

   property p_sp_align;
      msp_r[1:0] == 2'h0 && psp_r[1:0] == 2'h0 && pc_r[0] == 1'b0;
   endproperty
   a_sp_align: assert property (p_sp_align) else $error("pointer misaligned");

   property p_call_link;
      CALL_EN |=> lr_r == $past(CALL_RET_ADDR);
   endproperty
   a_call_link: assert property (p_call_link) else $error("link not loaded");

   property p_exc_num;
      (EXC_ENTER && !EXC_RETURN) |=> rd_word(`CPMSR_IDX_IRQ_STATUS_PART) == {23'h000000, $past(EXC_NUM)};
   endproperty
   a_exc_num: assert property (p_exc_num) else $error("exception number lost");

   property p_tbit;
      psw_word[`CPMSR_TBIT] and (f_tbit |=> FAULT && $stable(it_r));
   endproperty
   a_tbit: assert property (p_tbit) else $error("state bit rule broken");

   property p_masks;
      (flt_r |-> IRQ_ACCEPT == (IRQ_KIND == `CPMSR_KIND_NMI))
      and ((pri_r && !flt_r && IRQ_KIND == `CPMSR_KIND_HARD) |-> IRQ_ACCEPT);
   endproperty
   a_masks: assert property (p_masks) else $error("mask bit ignored");

   property p_threshold;
      (IRQ_KIND[1] && !pri_r && !flt_r) |-> IRQ_ACCEPT == (bpri_r == '0 || IRQ_PRIO < bpri_r);
   endproperty
   a_threshold: assert property (p_threshold) else $error("threshold wrong");

   property p_handler_spsel;
      handler |-> !ctrl_r[1];
   endproperty
   a_handler_spsel: assert property (p_handler_spsel) else $error("stack select set in handler");
endmodule

// >>> hw/cpmsr_defines.svh
`ifndef CPMSR_DEFINES_SVH
`define CPMSR_DEFINES_SVH
`define CPMSR_IDX_SP 5'h0D
`define CPMSR_IDX_LR 5'h0E
`define CPMSR_IDX_PC 5'h0F
`define CPMSR_IDX_PSW 5'h10
`define CPMSR_IDX_APP_STATUS_PART 5'h11
`define CPMSR_IDX_IRQ_STATUS_PART 5'h12
`define CPMSR_IDX_EXEC_STATUS_PART 5'h13
`define CPMSR_IDX_MSP 5'h14
`define CPMSR_IDX_PSP 5'h15
`define CPMSR_IDX_PRI 5'h16
`define CPMSR_IDX_FLT 5'h17
`define CPMSR_IDX_BPRI 5'h18
`define CPMSR_IDX_CTRL 5'h19
`define CPMSR_IDX_STAT 5'h1C
`define CPMSR_SPR_BASE 5'h10
`define CPMSR_SEL_APP_STATUS_PART 4'h1
`define CPMSR_HIGH_LO 5'h08
`define CPMSR_HIGH_HI 5'h0C
`define CPMSR_SP_MASK 32'hFFFFFFFC
`define CPMSR_PC_MASK 32'hFFFFFFFE
`define CPMSR_TBIT 24
`define CPMSR_RESP_OKAY 2'h0
`define CPMSR_RESP_SLVERR 2'h2
`define CPMSR_KIND_NMI 2'h0
`define CPMSR_KIND_HARD 2'h1
`define CPMSR_RST_WORD 32'h00000000
`endif

// >>> hw/cpmsr_pkg.sv
package cpmsr_pkg;
   typedef enum logic [1:0] {CPMSR_PRIV_HANDLER, CPMSR_PRIV_THREAD, CPMSR_USER_THREAD} cpmsr_mode_e;
   typedef logic [31:0] cpmsr_word_t;
   typedef logic [4:0] cpmsr_idx_t;
endpackage

// >>> test/cpu_privilege_mode_special_regs_tb.sv
`timescale 1ns/1ps
`include "cpmsr_defines.svh"
module cpu_privilege_mode_special_regs_tb import cpmsr_pkg::*; ;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, gpr_wr_data = 32'h0, spr_wr_data = 32'h0, call_ret_addr = 32'h0;
   logic [3:0] wstrb = 4'hF, gpr_rd_idx = 4'h0, gpr_wr_idx = 4'h0, spr_sel = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic gpr_we = 1'h0, gpr_narrow = 1'h0, spr_we = 1'h0, spr_re = 1'h0, restricted_op = 1'h0;
   logic call_en = 1'h0, exc_enter = 1'h0, exc_return = 1'h0;
   logic [8:0] exc_num = 9'h0, irq_prio = 9'h0;
   logic [1:0] irq_kind = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, irq_accept, fault, psp_active;
   logic [1:0] bresp, rresp, mode;
   logic [31:0] rdata, gpr_rd_data, spr_rd_data;
   int err_count = 0;
   int comparisons = 0;

   cpmsr_core_regs i_cpmsr_core_regs (
      .CORE_CLK(core_clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .GPR_RD_IDX(gpr_rd_idx), .GPR_RD_DATA(gpr_rd_data), .GPR_WE(gpr_we),
      .GPR_WR_IDX(gpr_wr_idx), .GPR_WR_DATA(gpr_wr_data), .GPR_NARROW(gpr_narrow),
      .SPR_WE(spr_we), .SPR_RE(spr_re), .SPR_SEL(spr_sel), .SPR_WR_DATA(spr_wr_data),
      .SPR_RD_DATA(spr_rd_data), .RESTRICTED_OP(restricted_op), .CALL_EN(call_en),
      .CALL_RET_ADDR(call_ret_addr), .EXC_ENTER(exc_enter), .EXC_NUM(exc_num),
      .EXC_RETURN(exc_return), .IRQ_KIND(irq_kind), .IRQ_PRIO(irq_prio),
      .IRQ_ACCEPT(irq_accept), .FAULT(fault), .MODE(mode), .PSP_ACTIVE(psp_active)
   );

   always #20 core_clk = ~core_clk;

   task automatic chk(input string name, input cpmsr_word_t seen, input cpmsr_word_t exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic hang(input string name);
      err_count++;
      $display("MISMATCH %s expected answer seen none", name);
      report_and_stop();
   endtask

   task automatic axi_wr(input logic [7:0] a, input cpmsr_word_t d, output logic [1:0] r);
      logic aw_ok, w_ok, b_ok;
      b_ok = 1'h0;
      @(posedge core_clk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= d;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; n < 40 && !b_ok; n++) begin
         @(negedge core_clk);
         aw_ok = awvalid & awready;
         w_ok = wvalid & wready;
         b_ok = bvalid & bready;
         r = bresp;
         @(posedge core_clk);
         if (aw_ok) awvalid <= 1'h0;
         if (w_ok) wvalid <= 1'h0;
         if (b_ok) bready <= 1'h0;
      end
      if (!b_ok) hang("write response");
   endtask

   task automatic axi_rd(input logic [7:0] a, output cpmsr_word_t d, output logic [1:0] r);
      logic ar_ok, r_ok;
      r_ok = 1'h0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; n < 40 && !r_ok; n++) begin
         @(negedge core_clk);
         ar_ok = arvalid & arready;
         r_ok = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (ar_ok) arvalid <= 1'h0;
         if (r_ok) rready <= 1'h0;
      end
      if (!r_ok) hang("read data");
   endtask

   task automatic rd_chk(input logic [7:0] a, input cpmsr_word_t exp, input string name);
      cpmsr_word_t d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(name, d, exp);
   endtask

   task automatic end_pulse(input logic exp_fault);
      @(posedge core_clk);
      gpr_we <= 1'h0;
      spr_we <= 1'h0;
      spr_re <= 1'h0;
      restricted_op <= 1'h0;
      call_en <= 1'h0;
      exc_enter <= 1'h0;
      exc_return <= 1'h0;
      @(negedge core_clk);
      chk("FAULT", fault, exp_fault);
   endtask

   task automatic gpr_wr(input logic [3:0] i, input cpmsr_word_t d, input logic nar, input logic f);
      @(posedge core_clk);
      gpr_we <= 1'h1;
      gpr_wr_idx <= i;
      gpr_wr_data <= d;
      gpr_narrow <= nar;
      end_pulse(f);
   endtask

   task automatic gpr_chk(input logic [3:0] i, input cpmsr_word_t exp);
      @(posedge core_clk);
      gpr_rd_idx <= i;
      @(posedge core_clk);
      @(negedge core_clk);
      chk("GPR_RD_DATA", gpr_rd_data, exp);
   endtask

   task automatic spr_op(input logic we, input logic [3:0] s, input cpmsr_word_t d, input logic f);
      @(posedge core_clk);
      spr_we <= we;
      spr_re <= ~we;
      spr_sel <= s;
      spr_wr_data <= d;
      end_pulse(f);
   endtask

   task automatic state_chk(input logic [1:0] m, input logic p);
      @(negedge core_clk);
      chk("MODE", mode, m);
      chk("PSP_ACTIVE", psp_active, p);
   endtask

   task automatic irq_chk(input logic [1:0] k, input logic [8:0] p, input logic exp);
      @(posedge core_clk);
      irq_kind <= k;
      irq_prio <= p;
      @(negedge core_clk);
      chk("IRQ_ACCEPT", irq_accept, exp);
   endtask

   task automatic t_regs();
      logic [1:0] r;
      cpmsr_word_t d;
      state_chk(2'h1, 1'h0);
      rd_chk(8'h40, 32'h01000000, "psw reset");
      axi_rd(8'h68, d, r);
      chk("unmapped rresp", r, `CPMSR_RESP_SLVERR);
      axi_wr(8'h50, 32'hFFFFFFFF, r);
      rd_chk(8'h34, 32'hFFFFFFFC, "sp aligned");
      axi_wr(8'h3C, 32'hFFFFFFFF, r);
      rd_chk(8'h3C, 32'hFFFFFFFE, "pc aligned");
      @(posedge core_clk);
      call_en <= 1'h1;
      call_ret_addr <= 32'h89ABCDEF;
      end_pulse(1'h0);
      rd_chk(8'h38, 32'h89ABCDEF, "link");
      gpr_wr(4'h3, 32'h80000001, 1'h0, 1'h0);
      rd_chk(8'h0C, 32'h80000001, "gpr3");
      gpr_chk(4'hD, 32'hFFFFFFFC);
      $display("test regs done");
   endtask

   task automatic t_psw();
      logic [1:0] r;
      axi_wr(8'h40, 32'hF9000000, r);
      rd_chk(8'h44, 32'hF8000000, "app part");
      axi_wr(8'h4C, 32'h0700FC00, r);
      rd_chk(8'h4C, 32'h0700FC00, "exec part");
      rd_chk(8'h40, 32'hFF00FC00, "psw whole");
      spr_op(1'h0, 4'h0, 32'h0, 1'h0);
      chk("SPR_RD_DATA", spr_rd_data, 32'hFF00FC00);
      axi_wr(8'h40, 32'h00000000, r);
      chk("bresp", r, `CPMSR_RESP_SLVERR);
      rd_chk(8'h40, 32'hFF00FC00, "psw kept");
      spr_op(1'h1, 4'h3, 32'h0, 1'h1);
      $display("test psw done");
   endtask

   task automatic t_control();
      logic [1:0] r;
      axi_wr(8'h50, 32'h100, r);
      axi_wr(8'h54, 32'h200, r);
      axi_wr(8'h64, 32'h2, r);
      state_chk(2'h1, 1'h1);
      rd_chk(8'h34, 32'h200, "alt stack");
      axi_wr(8'h64, 32'h0, r);
      rd_chk(8'h34, 32'h100, "main stack");
      axi_wr(8'h64, 32'h1, r);
      state_chk(2'h2, 1'h1);
      rd_chk(8'h34, 32'h200, "user stack");
      $display("test control done");
   endtask

   task automatic t_faults();
      logic [1:0] r;
      spr_op(1'h0, 4'h0, 32'h0, 1'h1);
      @(posedge core_clk);
      restricted_op <= 1'h1;
      end_pulse(1'h1);
      spr_op(1'h1, 4'h1, 32'h0, 1'h0);
      spr_op(1'h1, 4'h9, 32'h0, 1'h1);
      state_chk(2'h2, 1'h1);
      axi_wr(8'h64, 32'h0, r);
      spr_op(1'h0, 4'h0, 32'h0, 1'h0);
      chk("SPR_RD_DATA", spr_rd_data, 32'h0700FC00);
      @(posedge core_clk);
      restricted_op <= 1'h1;
      end_pulse(1'h0);
      spr_op(1'h1, 4'h9, 32'h2, 1'h0);
      state_chk(2'h1, 1'h1);
      axi_wr(8'h64, 32'h0, r);
      rd_chk(8'h70, 32'h3, "sticky fault");
      axi_wr(8'h70, 32'h1, r);
      rd_chk(8'h70, 32'h2, "sticky cleared");
      $display("test faults done");
   endtask

   task automatic t_narrow();
      gpr_wr(4'h8, 32'h11111111, 1'h0, 1'h0);
      gpr_wr(4'h8, 32'h22222222, 1'h1, 1'h1);
      gpr_chk(4'h8, 32'h11111111);
      gpr_wr(4'hC, 32'h44444444, 1'h1, 1'h1);
      gpr_wr(4'h7, 32'h33333333, 1'h1, 1'h0);
      gpr_chk(4'h7, 32'h33333333);
      gpr_wr(4'hC, 32'h55555555, 1'h0, 1'h0);
      gpr_chk(4'hC, 32'h55555555);
      $display("test narrow done");
   endtask

   task automatic t_exception();
      logic [1:0] r;
      axi_wr(8'h64, 32'h3, r);
      state_chk(2'h2, 1'h1);
      @(posedge core_clk);
      exc_enter <= 1'h1;
      exc_num <= 9'h1A5;
      end_pulse(1'h0);
      state_chk(2'h0, 1'h0);
      rd_chk(8'h48, 32'h1A5, "irq part");
      rd_chk(8'h64, 32'h1, "control in handler");
      axi_wr(8'h64, 32'h3, r);
      rd_chk(8'h64, 32'h1, "control kept");
      gpr_chk(4'hD, 32'h100);
      @(posedge core_clk);
      restricted_op <= 1'h1;
      end_pulse(1'h0);
      @(posedge core_clk);
      exc_return <= 1'h1;
      end_pulse(1'h0);
      state_chk(2'h2, 1'h1);
      axi_wr(8'h64, 32'h0, r);
      $display("test exception done");
   endtask

   task automatic t_masks();
      logic [1:0] r;
      irq_chk(2'h2, 9'h1FF, 1'h1);
      axi_wr(8'h60, 32'hFFFFFFFF, r);
      rd_chk(8'h60, 32'h1FF, "threshold width");
      irq_chk(2'h2, 9'h1FF, 1'h0);
      irq_chk(2'h2, 9'h1FE, 1'h1);
      axi_wr(8'h60, 32'h10, r);
      irq_chk(2'h3, 9'h010, 1'h0);
      irq_chk(2'h3, 9'h00F, 1'h1);
      irq_chk(2'h2, 9'h011, 1'h0);
      axi_wr(8'h60, 32'h0, r);
      axi_wr(8'h58, 32'h1, r);
      irq_chk(2'h0, 9'h1FF, 1'h1);
      irq_chk(2'h1, 9'h1FF, 1'h1);
      irq_chk(2'h3, 9'h000, 1'h0);
      axi_wr(8'h58, 32'h0, r);
      axi_wr(8'h5C, 32'h1, r);
      irq_chk(2'h0, 9'h1FF, 1'h1);
      irq_chk(2'h1, 9'h1FF, 1'h0);
      irq_chk(2'h2, 9'h000, 1'h0);
      $display("test masks done");
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'h0;
      t_regs();
      t_psw();
      t_control();
      t_faults();
      t_narrow();
      t_exception();
      t_masks();
      report_and_stop();
   end
endmodule
